/* File: verilog/mris_ref_select.sv */
// Function
// - Turn on a switch only after the opposite gate sense reads off.
// - Speed mode runs a PI loop on speed against the reference.
// - Power mode runs a PI loop on inverter input power.
// - Current mode runs a PI loop on the torque current.
// - Voltage mode drives the reference straight out, no loop.
// - Source code 00 takes the duty command from the analog pin level.
// - Analog: zero below standby, linear to full scale, clamp at 100%.
// - Source code 01 takes duty linearly from pulse duty, zero below standby.
// - Pulse frequencies are accepted within the selected range only.
// - Accepted pulse frequency is unrelated to motor switching frequency.
// - Source code 10 takes the command from the host reference value.
// - Host mode sleeps when pin low after host zero longer than delay.
// - Host mode wakes when pin rises above exit, then follows host value.
// - Host mode stays in standby while host value is at or below threshold.
// - Source code 11 takes duty linearly from pin frequency, zero below standby.
// - Frequency above full scale clamps the duty command to 100%.
// - Reference kind selects speed, power, current or voltage meaning.
// - Speed, power, current reference is output over 255 times full scale.
// - Voltage reference kind uses profiler output as modulation index.
// - Profile code 00 passes the duty command straight through.
// - Profile codes 01, 10, 11 (linear, staircase, forward-reverse) are only latched out; duty still passes straight through.
`default_nettype none
module mris_ref_select #(
    // Slowest accepted pulse period per range, in clock cycles.
    parameter logic [3:0][21:0] RANGE_MAX_PER = {22'd400_000, 22'd400_000,
                                                  22'd4_000_000, 22'd4_000_000}
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire mris_pkg::mris_cfg_t cfg,
    input wire mris_pkg::mris_fb_t fb,
    input wire logic [11:0] ana_level,
    input wire logic ref_pin,
    input wire logic pin_below_sleep_entry,
    input wire logic pin_above_sleep_exit,
    input wire logic [7:0] host_ref,
    input wire logic [2:0] hs_req,
    input wire logic [2:0] ls_req,
    input wire logic [2:0] hs_vgs_on,
    input wire logic [2:0] ls_vgs_on,
    output logic [2:0] gate_hs_ff,
    output logic [2:0] gate_ls_ff,
    output logic [7:0] duty_cmd_ff,
    output logic [1:0] profile_mode_ff,
    output logic [15:0] ref_value_ff,
    output logic [15:0] ctrl_out,
    output logic standby_ff,
    output logic sleep_ff
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lin_scale(input logic [31:0] val,
                                             input logic [31:0] lo,
                                             input logic [31:0] hi);
        logic [39:0] prod;
        prod = '0;
        if (val >= hi) begin
            lin_scale = mris_pkg::DUTY_FULL;
        end else if (val <= lo) begin
            lin_scale = 8'h00;
        end else begin
            prod = 40'(val - lo) * 40'(mris_pkg::DUTY_FULL);
            lin_scale = 8'(prod / 40'(hi - lo));
        end
    endfunction

    // Between the two thresholds the previous state is kept.
    function automatic logic hyst(input logic act, input logic [31:0] val,
                                  input logic [31:0] enter, input logic [31:0] leave);
        if (act) begin
            hyst = val > enter;
        end else begin
            hyst = val >= leave;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pulse input measurement.
    logic pin_prev_ff;
    logic [21:0] per_cnt_ff;
    logic [21:0] high_cnt_ff;
    logic [21:0] per_ff;
    logic [21:0] high_ff;
    logic meas_valid_ff;
    logic rise;
    logic [21:0] per_min;
    logic [21:0] per_max;

    assign rise = ref_pin && !pin_prev_ff;
    assign per_min = 22'(mris_pkg::CLK_HZ / mris_pkg::RANGE_FMAX_HZ[cfg.range_sel]);
    assign per_max = RANGE_MAX_PER[cfg.range_sel];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_prev_ff <= 1'b0;
        end else begin
            pin_prev_ff <= ref_pin;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            per_cnt_ff <= mris_pkg::PER_RST;
            high_cnt_ff <= mris_pkg::PER_RST;
            per_ff <= mris_pkg::PER_RST;
            high_ff <= mris_pkg::PER_RST;
            meas_valid_ff <= 1'b0;
        end else if (rise) begin
            per_ff <= per_cnt_ff + 22'd1;
            high_ff <= high_cnt_ff;
            meas_valid_ff <= (per_cnt_ff + 22'd1) >= per_min;
            per_cnt_ff <= mris_pkg::PER_RST;
            high_cnt_ff <= 22'd1;
        end else if (per_cnt_ff >= per_max) begin
            // No edge within the slowest period: pin is a steady level.
            meas_valid_ff <= 1'b0;
            per_ff <= mris_pkg::PER_RST;
        end else begin
            per_cnt_ff <= per_cnt_ff + 22'd1;
            high_cnt_ff <= high_cnt_ff + 22'(ref_pin);
        end
    end

    logic [7:0] pwm_pct;
    logic [15:0] freq_hz;
    logic [31:0] freq_raw;
    always_comb begin
        freq_raw = 32'h0000_0000;
        if (meas_valid_ff && per_ff != mris_pkg::PER_RST) begin
            pwm_pct = 8'((40'(high_ff) * 40'(mris_pkg::DUTY_FULL)) / 40'(per_ff));
            freq_raw = mris_pkg::CLK_HZ / 32'(per_ff);
            // Rates beyond the 16-bit field saturate, so the full-scale clamp still holds.
            freq_hz = (freq_raw > 32'h0000_ffff) ? 16'hffff : freq_raw[15:0];
        end else begin
            pwm_pct = ref_pin ? mris_pkg::DUTY_FULL : 8'h00;
            freq_hz = 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection and standby hysteresis.
    logic active_ff;
    logic nxt_active;
    logic [7:0] nxt_duty;

    always_comb begin
        case (cfg.src_sel)
            mris_pkg::SRC_ANALOG: begin
                nxt_active = hyst(active_ff, 32'(ana_level), 32'(cfg.ana_sb_enter),
                                  32'(cfg.ana_sb_exit));
                nxt_duty = nxt_active ? lin_scale(32'(ana_level), 32'(cfg.ana_sb_exit),
                                                  32'(cfg.ana_full_scale)) : 8'h00;
            end
            mris_pkg::SRC_PWM: begin
                nxt_active = hyst(active_ff, 32'(pwm_pct), 32'(cfg.duty_sb_enter),
                                  32'(cfg.duty_sb_exit));
                nxt_duty = nxt_active ? pwm_pct : 8'h00;
            end
            mris_pkg::SRC_HOST: begin
                nxt_active = host_ref > cfg.host_sb_thr;
                nxt_duty = nxt_active ? host_ref : 8'h00;
            end
            mris_pkg::SRC_FREQ: begin
                nxt_active = hyst(active_ff, 32'(freq_hz), 32'(cfg.freq_sb_enter),
                                  32'(cfg.freq_sb_exit));
                nxt_duty = nxt_active ? lin_scale(32'(freq_hz), 32'(cfg.freq_sb_exit),
                                                  32'(cfg.freq_full_scale)) : 8'h00;
            end
            default: begin
                nxt_active = 1'b0;
                nxt_duty = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_ff <= 1'b0;
            duty_cmd_ff <= 8'h00;
        end else begin
            active_ff <= nxt_active;
            duty_cmd_ff <= (sleep_ff && cfg.src_sel == mris_pkg::SRC_HOST) ? 8'h00 : nxt_duty;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep and standby sequencing.
    mris_pkg::mris_state_t state_ff;
    mris_pkg::mris_state_t nxt_state;
    logic [23:0] zero_cnt_ff;
    logic zero_long;

    assign zero_long = zero_cnt_ff > cfg.sleep_entry_cyc;

    always_ff @(posedge ref_clk) begin
        if (rst || host_ref != 8'h00 || cfg.src_sel != mris_pkg::SRC_HOST) begin
            zero_cnt_ff <= 24'h00_0000;
        end else if (!zero_long) begin
            zero_cnt_ff <= zero_cnt_ff + 24'h00_0001;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mris_pkg::MRIS_RUN: begin
                if (!nxt_active) begin
                    nxt_state = mris_pkg::MRIS_STBY;
                end
            end
            mris_pkg::MRIS_STBY: begin
                if (cfg.src_sel == mris_pkg::SRC_HOST && zero_long && pin_below_sleep_entry) begin
                    nxt_state = mris_pkg::MRIS_SLEEP;
                end else if (nxt_active) begin
                    nxt_state = mris_pkg::MRIS_RUN;
                end
            end
            mris_pkg::MRIS_SLEEP: begin
                if (cfg.src_sel != mris_pkg::SRC_HOST || pin_above_sleep_exit) begin
                    nxt_state = nxt_active ? mris_pkg::MRIS_RUN : mris_pkg::MRIS_STBY;
                end
            end
            default: begin
                nxt_state = mris_pkg::MRIS_STBY;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= mris_pkg::MRIS_STBY;
            standby_ff <= 1'b1;
            sleep_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            standby_ff <= nxt_state == mris_pkg::MRIS_STBY;
            sleep_ff <= nxt_state == mris_pkg::MRIS_SLEEP;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Profiler and reference scaling.
    logic [7:0] prof_out;
    logic [15:0] full_scale;
    logic [15:0] fb_sel;

    // shape code latched for the shaping stage
    assign prof_out = duty_cmd_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            profile_mode_ff <= mris_pkg::PROF_DIRECT;
        end else begin
            profile_mode_ff <= cfg.profile_sel;
        end
    end

    always_comb begin
        case (cfg.kind_sel)
            mris_pkg::KIND_SPEED: begin
                full_scale = cfg.max_speed;
                fb_sel = fb.speed;
            end
            mris_pkg::KIND_POWER: begin
                full_scale = cfg.max_power;
                fb_sel = fb.power;
            end
            mris_pkg::KIND_CURRENT: begin
                full_scale = cfg.full_scale_current_limit;
                fb_sel = fb.iq;
            end
            default: begin
                full_scale = 16'h0000;
                fb_sel = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_value_ff <= 16'h0000;
        end else if (cfg.kind_sel == mris_pkg::KIND_VOLTAGE) begin
            ref_value_ff <= {prof_out, prof_out};
        end else begin
            ref_value_ff <= 16'((24'(prof_out) * 24'(full_scale)) / 24'(mris_pkg::PROF_DIV));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control loop.
    logic [15:0] tick_cnt_ff;
    logic tick_ff;

    always_ff @(posedge ref_clk) begin
        if (rst || tick_cnt_ff == mris_pkg::LOOP_DIV - 16'h0001) begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= !rst;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    mris_pi u_pi (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick_ff),
        .bypass(cfg.kind_sel == mris_pkg::KIND_VOLTAGE),
        .hold(state_ff != mris_pkg::MRIS_RUN),
        .set_point(ref_value_ff),
        .feedback(fb_sel),
        .kp(cfg.kp),
        .ki(cfg.ki),
        .out_ff(ctrl_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Gate-sensed dead time: a switch turns on only once the opposite gate is off.
    // gate interlock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gate_hs_ff <= 3'h0;
            gate_ls_ff <= 3'h0;
        end else begin
            gate_hs_ff <= hs_req & ~ls_req & (gate_hs_ff | (~ls_vgs_on & ~gate_ls_ff));
            gate_ls_ff <= ls_req & ~hs_req & (gate_ls_ff | (~hs_vgs_on & ~gate_hs_ff));
        end
    end
endmodule // mris_ref_select
`default_nettype wire

/* File: verilog/mris_pkg.sv */
`default_nettype none
package mris_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // Reference source select codes.
    localparam logic [1:0] SRC_ANALOG = 2'h0;
    localparam logic [1:0] SRC_PWM = 2'h1;
    localparam logic [1:0] SRC_HOST = 2'h2;
    localparam logic [1:0] SRC_FREQ = 2'h3;
    // Profile shape select codes.
    localparam logic [1:0] PROF_DIRECT = 2'h0;
    localparam logic [1:0] PROF_LINEAR = 2'h1;
    localparam logic [1:0] PROF_STAIR = 2'h2;
    localparam logic [1:0] PROF_FWDREV = 2'h3;
    // Reference kind select codes.
    localparam logic [1:0] KIND_SPEED = 2'h0;
    localparam logic [1:0] KIND_POWER = 2'h1;
    localparam logic [1:0] KIND_CURRENT = 2'h2;
    localparam logic [1:0] KIND_VOLTAGE = 2'h3;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [15:0] PROF_DIV = 16'h00ff;
    // Control loop update rate, 10 kHz.
    localparam int unsigned LOOP_HZ = 10_000;
    localparam logic [15:0] LOOP_DIV = 16'(CLK_HZ / LOOP_HZ);
    // Pulse input highest frequency per range, in Hz.
    localparam int unsigned RANGE_FMAX_HZ [4] = '{1_000, 10_000, 50_000, 100_000};
    localparam int unsigned PER_W = 22;
    localparam logic [PER_W-1:0] PER_RST = 22'h00_0000;
    localparam logic [1:0] SRC_RST = 2'h0;

    typedef struct packed {
        logic [1:0] src_sel;
        logic [1:0] profile_sel;
        logic [1:0] kind_sel;
        logic [1:0] range_sel;
        logic [11:0] ana_sb_enter;
        logic [11:0] ana_sb_exit;
        logic [11:0] ana_full_scale;
        logic [7:0] duty_sb_enter;
        logic [7:0] duty_sb_exit;
        logic [15:0] freq_sb_enter;
        logic [15:0] freq_sb_exit;
        logic [15:0] freq_full_scale;
        logic [7:0] host_sb_thr;
        logic [23:0] sleep_entry_cyc;
        logic [15:0] max_speed;
        logic [15:0] max_power;
        logic [15:0] full_scale_current_limit;
        logic [7:0] kp;
        logic [7:0] ki;
    } mris_cfg_t;

    typedef struct packed {
        logic [15:0] speed;
        logic [15:0] power;
        logic [15:0] iq;
    } mris_fb_t;

    typedef enum logic [2:0] {
        MRIS_RUN = 3'b001,
        MRIS_STBY = 3'b010,
        MRIS_SLEEP = 3'b100
    } mris_state_t;
endpackage
`default_nettype wire

/* File: verilog/mris_pi.sv */
`default_nettype none
module mris_pi (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic bypass,
    input wire logic hold,
    input wire logic [15:0] set_point,
    input wire logic [15:0] feedback,
    input wire logic [7:0] kp,
    input wire logic [7:0] ki,
    output logic [15:0] out_ff
);
    logic signed [16:0] err;
    logic signed [31:0] integ_ff;
    logic signed [31:0] nxt_integ;
    logic signed [31:0] sum;

    assign err = $signed({1'b0, set_point}) - $signed({1'b0, feedback});
    assign nxt_integ = integ_ff + 32'(err * $signed({1'b0, ki}));
    assign sum = (32'(err * $signed({1'b0, kp})) + integ_ff) >>> 8;

    // Integrator is frozen while saturated with the error pushing further out, so it cannot wind up.
    always_ff @(posedge ref_clk) begin
        if (rst || hold || bypass) begin
            integ_ff <= '0;
        end else if (tick && !((sum > 32'sd65535 && err > 0) || (sum < 0 && err < 0))) begin
            integ_ff <= nxt_integ;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || hold) begin
            out_ff <= 16'h0000;
        end else if (bypass) begin
            out_ff <= set_point;
        end else if (tick) begin
            if (sum > 32'sd65535) begin
                out_ff <= 16'hffff;
            end else if (sum < 0) begin
                out_ff <= 16'h0000;
            end else begin
                out_ff <= sum[15:0];
            end
        end
    end
endmodule // mris_pi
`default_nettype wire

/* File: sim/mris_src_model.sv */
`default_nettype none
module mris_src_model (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic idle_lvl,
    input wire logic [21:0] period,
    input wire logic [21:0] high,
    output logic ref_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [21:0] cnt;
    initial ref_pin = 1'b0;
    initial cnt = 22'h00_0000;
    // Pin is high for the first high cycles of every period; idle holds a steady level.
    always @(posedge ref_clk) begin
        if (!run) begin
            cnt <= 22'h00_0000;
            ref_pin <= idle_lvl;
        end else begin
            cnt <= (cnt + 22'h00_0001 >= period) ? 22'h00_0000 : cnt + 22'h00_0001;
            ref_pin <= (cnt < high);
        end
    end
endmodule // mris_src_model
`default_nettype wire

/* File: sim/mris_ref_select_assertions.sv */
`default_nettype none
module mris_ref_select_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire mris_pkg::mris_cfg_t cfg,
    input wire logic [11:0] ana_level,
    input wire logic [7:0] host_ref,
    input wire logic pin_above_sleep_exit,
    input wire logic [2:0] hs_req,
    input wire logic [2:0] ls_req,
    input wire logic [2:0] ls_vgs_on,
    input wire logic [2:0] gate_hs_ff,
    input wire logic [2:0] gate_ls_ff,
    input wire logic [7:0] duty_cmd_ff,
    input wire logic [15:0] ref_value_ff,
    input wire logic standby_ff,
    input wire logic sleep_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    property p_hs_on;
        (gate_hs_ff & ~$past(gate_hs_ff) & ($past(ls_req) | $past(ls_vgs_on))) == 3'h0;
    endproperty
    a_hs_on: assert property (p_hs_on)
        else $error("high gate rose with low side live");
    property p_gate_off;
        ((gate_hs_ff & ~$past(hs_req)) | (gate_ls_ff & ~$past(ls_req))) == 3'h0;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("gate still on after request drop");
    property p_no_overlap;
        (gate_hs_ff & gate_ls_ff) == 3'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both gates of a phase on");
    property p_ana_zero;
        !$past(rst) && $past(cfg.src_sel) == mris_pkg::SRC_ANALOG
            && $past(ana_level) <= $past(cfg.ana_sb_enter) |-> duty_cmd_ff == 8'h00;
    endproperty
    a_ana_zero: assert property (p_ana_zero)
        else $error("analog duty not zero at low level");
    property p_ana_full;
        !$past(rst) && $past(cfg.src_sel) == mris_pkg::SRC_ANALOG
            && $past(ana_level) > $past(cfg.ana_full_scale) |-> duty_cmd_ff == 8'hff;
    endproperty
    a_ana_full: assert property (p_ana_full)
        else $error("analog duty not clamped");
    property p_host_stby;
        !$past(rst) && $past(cfg.src_sel) == mris_pkg::SRC_HOST && !$past(sleep_ff)
            && !sleep_ff && $past(host_ref) <= $past(cfg.host_sb_thr) |-> standby_ff;
    endproperty
    a_host_stby: assert property (p_host_stby)
        else $error("host mode left standby at low value");
    property p_volt_ref;
        !$past(rst) && $past(cfg.kind_sel) == mris_pkg::KIND_VOLTAGE
            |-> ref_value_ff == {2{$past(duty_cmd_ff)}};
    endproperty
    a_volt_ref: assert property (p_volt_ref)
        else $error("voltage reference mismatch");
    property p_speed_ref;
        !$past(rst) && $past(cfg.kind_sel) == mris_pkg::KIND_SPEED |-> ref_value_ff
            == 16'((32'($past(duty_cmd_ff)) * 32'($past(cfg.max_speed))) / 32'd255);
    endproperty
    a_speed_ref: assert property (p_speed_ref)
        else $error("speed reference scaling mismatch");
    property p_wake;
        sleep_ff && pin_above_sleep_exit |=> !sleep_ff;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake after pin rose");
endmodule // mris_ref_select_assertions
bind mris_ref_select mris_ref_select_assertions mris_ref_select_assertions_inst (
    .ref_clk(ref_clk), .rst(rst), .cfg(cfg), .ana_level(ana_level), .host_ref(host_ref),
    .pin_above_sleep_exit(pin_above_sleep_exit), .hs_req(hs_req), .ls_req(ls_req),
    .ls_vgs_on(ls_vgs_on), .gate_hs_ff(gate_hs_ff), .gate_ls_ff(gate_ls_ff),
    .duty_cmd_ff(duty_cmd_ff), .ref_value_ff(ref_value_ff), .standby_ff(standby_ff),
    .sleep_ff(sleep_ff)
);
`default_nettype wire

/* File: sim/mris_ref_select_bench.sv */
`default_nettype none
module mris_ref_select_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk;
    logic rst;
    mris_pkg::mris_cfg_t cfg;
    mris_pkg::mris_fb_t fb;
    logic [11:0] ana_level;
    logic ref_pin;
    logic pin_below;
    logic pin_above;
    logic [7:0] host_ref;
    logic [2:0] hs_req;
    logic [2:0] ls_req;
    logic [2:0] hs_vgs;
    logic [2:0] ls_vgs;
    logic [2:0] gate_hs;
    logic [2:0] gate_ls;
    logic [7:0] duty;
    logic [1:0] prof;
    logic [15:0] ref_val;
    logic [15:0] ctrl_out;
    logic standby;
    logic sleep;
    logic src_run;
    logic src_idle;
    logic [21:0] src_per;
    logic [21:0] src_high;
    int failures;
    int check_count;
    logic [11:0] ana_lvl [5] = '{12'h080, 12'hF00, 12'h180, 12'h080, 12'h180};
    logic [4:0] ana_sb = 5'b11001;
    logic [15:0] kind_exp [4] = '{16'h0200, 16'h0100, 16'h0080, 16'h8080};
    mris_src_model mris_src_model_inst (.ref_clk(ref_clk), .run(src_run),
        .idle_lvl(src_idle), .period(src_per), .high(src_high), .ref_pin(ref_pin));
    mris_ref_select #(.RANGE_MAX_PER({4{22'h00_07D0}})) mris_ref_select_inst (
        .ref_clk(ref_clk), .rst(rst), .cfg(cfg), .fb(fb), .ana_level(ana_level),
        .ref_pin(ref_pin), .pin_below_sleep_entry(pin_below),
        .pin_above_sleep_exit(pin_above), .host_ref(host_ref), .hs_req(hs_req),
        .ls_req(ls_req), .hs_vgs_on(hs_vgs), .ls_vgs_on(ls_vgs), .gate_hs_ff(gate_hs),
        .gate_ls_ff(gate_ls), .duty_cmd_ff(duty), .profile_mode_ff(prof),
        .ref_value_ff(ref_val), .ctrl_out(ctrl_out), .standby_ff(standby), .sleep_ff(sleep));
    ////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_duty(input logic [7:0] exp);
        int n;
        n = 0;
        while (duty !== exp && n < 6000) begin
            step(1);
            n++;
        end
        if (n == 6000) begin
            failures++;
            final_report();
        end
        chk({8'h00, duty}, {8'h00, exp});
    endtask
    task automatic set_src(input logic r, input logic l, input logic [21:0] p,
                           input logic [21:0] h);
        src_run = r;
        src_idle = l;
        src_per = p;
        src_high = h;
    endtask
    ////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        failures = 0;
        check_count = 0;
        rst = 1'b1;
        cfg = '0;
        cfg.range_sel = 2'h3;
        cfg.kind_sel = mris_pkg::KIND_VOLTAGE;
        cfg.ana_sb_enter = 12'h100;
        cfg.ana_sb_exit = 12'h200;
        cfg.ana_full_scale = 12'hE00;
        cfg.freq_full_scale = 16'h7D00;
        cfg.host_sb_thr = 8'h10;
        cfg.sleep_entry_cyc = 24'h00_0800;
        cfg.max_speed = 16'h03FC;
        cfg.max_power = 16'h01FE;
        cfg.full_scale_current_limit = 16'h00FF;
        cfg.kp = 8'h10;
        cfg.ki = 8'h01;
        fb = '0;
        ana_level = 12'h000;
        pin_below = 1'b0;
        pin_above = 1'b0;
        host_ref = 8'h00;
        hs_req = 3'h0;
        ls_req = 3'h0;
        hs_vgs = 3'h0;
        ls_vgs = 3'h0;
        set_src(1'b0, 1'b0, 22'h00_03E8, 22'h00_01F4);
        step(8);
        chk({15'h0000, standby}, 16'h0001);
        rst = 1'b0;
        hs_req = 3'h7;
        step(2);
        chk({13'h0000, gate_hs}, 16'h0007);
        hs_req = 3'h0;
        ls_req = 3'h7;
        hs_vgs = 3'h7;
        step(3);
        chk({13'h0000, gate_ls}, 16'h0000);
        hs_vgs = 3'h0;
        step(2);
        chk({13'h0000, gate_ls}, 16'h0007);
        ls_req = 3'h0;
        hs_req = 3'h7;
        ls_vgs = 3'h7;
        step(3);
        chk({13'h0000, gate_hs}, 16'h0000);
        ls_vgs = 3'h0;
        step(2);
        chk({13'h0000, gate_hs}, 16'h0007);
        hs_req = 3'h0;
        $display("test gates done");
        for (int i = 0; i < 5; i++) begin
            ana_level = ana_lvl[i];
            step(3);
            chk({15'h0000, standby}, {15'h0000, ana_sb[i]});
            if (i != 2) begin
                chk({8'h00, duty}, (i == 1) ? 16'h00FF : 16'h0000);
            end
        end
        ana_level = 12'hF00;
        step(3);
        chk(ref_val, 16'hFFFF);
        step(8010);
        chk(ctrl_out, 16'hFFFF);
        $display("test analog done");
        cfg.src_sel = mris_pkg::SRC_PWM;
        set_src(1'b1, 1'b0, 22'h00_03E8, 22'h00_01F4);
        wait_duty(8'h7F);
        set_src(1'b1, 1'b0, 22'h00_03E8, 22'h00_00FA);
        wait_duty(8'h3F);
        set_src(1'b0, 1'b1, 22'h00_03E8, 22'h00_00FA);
        wait_duty(8'hFF);
        set_src(1'b0, 1'b0, 22'h00_03E8, 22'h00_00FA);
        wait_duty(8'h00);
        $display("test pulse done");
        cfg.src_sel = mris_pkg::SRC_FREQ;
        set_src(1'b1, 1'b0, 22'h00_0640, 22'h00_0320);
        wait_duty(8'hC7);
        set_src(1'b1, 1'b0, 22'h00_01F4, 22'h00_00FA);
        wait_duty(8'hFF);
        set_src(1'b0, 1'b0, 22'h00_0320, 22'h00_0190);
        wait_duty(8'h00);
        $display("test frequency done");
        cfg.src_sel = mris_pkg::SRC_HOST;
        pin_above = 1'b1;
        host_ref = 8'h80;
        step(3);
        chk({8'h00, duty}, 16'h0080);
        for (int k = 0; k < 4; k++) begin
            cfg.kind_sel = 2'(k);
            step(3);
            chk(ref_val, kind_exp[k]);
        end
        for (int p = 0; p < 4; p++) begin
            cfg.profile_sel = 2'(p);
            step(3);
            chk({14'h0000, prof}, 16'(p));
            chk(ref_val, 16'h8080);
        end
        for (int k = 0; k < 3; k++) begin
            cfg.kind_sel = 2'(k);
            step(8010);
            chk({15'h0000, ctrl_out != 16'h0000}, 16'h0001);
        end
        host_ref = 8'h10;
        step(3);
        chk({15'h0000, standby}, 16'h0001);
        host_ref = 8'h00;
        pin_above = 1'b0;
        pin_below = 1'b1;
        step(1000);
        chk({15'h0000, sleep}, 16'h0000);
        step(1100);
        chk({15'h0000, sleep}, 16'h0001);
        pin_below = 1'b0;
        pin_above = 1'b1;
        host_ref = 8'h80;
        step(2);
        chk({15'h0000, sleep}, 16'h0000);
        step(2);
        chk({8'h00, duty}, 16'h0080);
        $display("test host done");
        final_report();
    end
endmodule // mris_ref_select_bench
`default_nettype wire
